// file: pfm_port_function.sv
`timescale 1ns/1ps
// Notes on behaviour
// - every pin picks its function on its own, save port A, which the repeater takes whole
// - host sets level, direction; reads pin level
// - logic-array pins ignore host output writes
// - ports A and B output low address bits
// - port B may output high address bits
// - select bit one drives address, zero I/O
// - port B address select resets to zero
// - port D carries decode chip-selects, no macrocell
// - sixteen macrocells, buried or pin-driving, mixed
// - cell output feeds pin, bus, feedback together
// - XOR polarity, then registered or combinational
// - cells borrow spare terms from a neighbour
// - flop acts as D, T, JK or SR
// - own clock, preset, clear product terms
// - preset/clear level high, clock rising edge
// - optional shared clock pin for selected flops
// - each pin-driving cell routes to one A/B/C pin
// - port A repeats host data, strobes set direction
// - repeater only inside either OR'ed range select
// - repeater waits for enable bit seven set
// - repeater takes all eight port A pins
module pfm_port_function
  import pfm_pkg::*;
#(
  parameter int CELL_N = CELL_COUNT
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  // host processor bus
  input  wire pfm_host_t                     hostBus,
  output logic [7:0]                         hostRdData,
  output logic                               hostRdValid,
  // static configuration
  input  wire logic [2:0][7:0]               logicPinMask,
  input  wire logic                          portBHighAddr,
  input  wire logic                          portARepeater,
  input  wire logic [7:0]                    chipSelMask,
  input  wire logic                          sharedClkEn,
  input  wire pfm_cell_cfg_t [CELL_N-1:0]    cellCfg,
  // logic arrays
  input  wire pfm_cell_pt_t [CELL_N-1:0]     cellPt,
  input  wire logic [7:0]                    chipSelect,
  input  wire logic                          rangeSelFirst,
  input  wire logic                          rangeSelSecond,
  output logic [CELL_N-1:0]                  cellFeedback,
  // port pins, index 0 to 3 is port A to D
  input  wire logic [3:0][7:0]               pinIn,
  output logic [3:0][7:0]                    pinOut,
  output logic [3:0][7:0]                    pinOeN
);

  // ==========================================================
  // declarations
  logic [3:0][7:0]          outData_q;
  logic [3:0][7:0]          dir_q;
  logic [7:0]               addrSelA_q;
  logic [7:0]               addrSelB_q;
  logic [7:0]               memMap_q;
  logic [15:0]              addrLatch_q;
  logic                     sharedPrev_q;
  logic                     sharedRise;
  logic [7:0]               regOfs;
  logic                     csiopWr;
  logic                     csiopRd;
  logic [7:0]               rdVal;
  logic [7:0]               hostRdData_q;
  logic                     hostRdValid_q;
  logic [CELL_N-1:0]        cellOut;
  logic [CELL_N-1:0]        spareTerm;
  logic [15:0]              cellVec;
  logic [2:0][7:0]          cellPin;
  logic                     repeaterMode;
  logic                     rangeHit;
  logic                     repActive;
  logic                     repDrive;
  logic                     repRead;
  pfm_pin_src_t [3:0][7:0]  pinSrc;

  assign regOfs  = hostBus.addr[7:0];
  assign csiopWr = hostBus.csiopSel & hostBus.wr;
  assign csiopRd = hostBus.csiopSel & hostBus.rd;

  // ==========================================================
  // port data, direction and mode registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      outData_q  <= {PORT_COUNT{RST_PORT_REG}};
      dir_q      <= {PORT_COUNT{RST_PORT_REG}};
      addrSelA_q <= RST_PORT_REG;
      addrSelB_q <= RST_ADDR_SEL_B;
      memMap_q   <= RST_PORT_REG;
    end else if (csiopWr) begin
      if (regOfs[7:2] == OFS_OUT_BASE[7:2]) begin
        outData_q[regOfs[1:0]] <= hostBus.wrData;
      end else if (regOfs[7:2] == OFS_DIR_BASE[7:2]) begin
        dir_q[regOfs[1:0]] <= hostBus.wrData;
      end else if (regOfs == OFS_ADDR_SEL_A) begin
        addrSelA_q <= hostBus.wrData;
      end else if (regOfs == OFS_ADDR_SEL_B) begin
        addrSelB_q <= hostBus.wrData;
      end else if (regOfs == OFS_MEM_MAP) begin
        memMap_q <= hostBus.wrData;
      end
    end
  end

  // ==========================================================
  // demultiplexed address held from the latch strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addrLatch_q <= 16'h0000;
    end else if (hostBus.ale) begin
      addrLatch_q <= hostBus.addr;
    end
  end

  // ==========================================================
  // shared clock pin edge, pin taken as synchronous
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sharedPrev_q <= 1'b0;
    end else begin
      sharedPrev_q <= pinIn[3][1];
    end
  end

  assign sharedRise = sharedClkEn & pinIn[3][1] & ~sharedPrev_q;

  // ==========================================================
  // output macrocells, spare terms passed down a ring
  for (genvar c = 0; c < CELL_N; c++) begin : g_cell
    pfm_output_macrocell u_cell (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .cfg        (cellCfg[c]),
      .pt         (cellPt[c]),
      .sharedRise (sharedRise),
      .borrowIn   (spareTerm[(c + 1) % CELL_N]),
      .spareOut   (spareTerm[c]),
      .cellOut    (cellOut[c])
    );
  end

  // same value goes to feedback, bus reads and the allocator
  assign cellFeedback = cellOut;
  assign cellVec      = 16'(cellOut);

  // ==========================================================
  // allocator: one pin per cell, lowest cell wins a clash
  always_comb begin
    cellPin = '0;
    for (int c = CELL_N - 1; c >= 0; c--) begin
      if (cellCfg[c].route != RT_NONE) begin
        cellPin[cellCfg[c].route][cellCfg[c].routeBit] = cellOut[c];
      end
    end
  end

  // ==========================================================
  // data bus repeater on port A
  assign repeaterMode = portARepeater
                      & memMap_q[REPEATER_EN_BIT];
  assign rangeHit     = rangeSelFirst | rangeSelSecond;
  assign repActive    = repeaterMode & rangeHit & ~hostBus.csiopSel;
  assign repDrive     = repActive & hostBus.wr;
  assign repRead      = repActive & hostBus.rd;

  // ==========================================================
  // candidate sources per pin
  always_comb begin
    for (int p = 0; p < PORT_COUNT; p++) begin
      for (int b = 0; b < PORT_BITS; b++) begin
        pinSrc[p][b]        = '0;
        pinSrc[p][b].ioDir  = dir_q[p][b];
        pinSrc[p][b].ioData = outData_q[p][b];
      end
    end
    for (int b = 0; b < PORT_BITS; b++) begin
      pinSrc[0][b].useRep   = portARepeater;
      pinSrc[0][b].repDrive = repDrive;
      pinSrc[0][b].repData  = hostBus.wrData[b];
      for (int p = 0; p < 3; p++) begin
        pinSrc[p][b].useLogic  = logicPinMask[p][b];
        pinSrc[p][b].logicData = cellPin[p][b];
      end
      pinSrc[0][b].useAddr  = addrSelA_q[b];
      pinSrc[0][b].addrData = addrLatch_q[b];
      pinSrc[1][b].useAddr  = addrSelB_q[b];
      pinSrc[1][b].addrData = portBHighAddr ? addrLatch_q[b + 8]
                                            : addrLatch_q[b];
      pinSrc[3][b].useCs    = chipSelMask[b];
      pinSrc[3][b].csData   = chipSelect[b];
    end
    pinSrc[3][1].forceIn = sharedClkEn;
  end

  // ==========================================================
  // pin drivers
  for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
    for (genvar b = 0; b < PORT_BITS; b++) begin : g_bit
      pfm_pin_cell u_pin (
        .sys_clk (sys_clk),
        .srst    (srst),
        .src     (pinSrc[p][b]),
        .pinOut  (pinOut[p][b]),
        .pinOeN  (pinOeN[p][b])
      );
    end
  end

  // ==========================================================
  // read decode
  always_comb begin
    rdVal = RD_UNMAPPED;
    if (regOfs[7:2] == OFS_IN_BASE[7:2]) begin
      rdVal = pinIn[regOfs[1:0]];
    end else if (regOfs[7:2] == OFS_OUT_BASE[7:2]) begin
      rdVal = outData_q[regOfs[1:0]];
    end else if (regOfs[7:2] == OFS_DIR_BASE[7:2]) begin
      rdVal = dir_q[regOfs[1:0]];
    end else if (regOfs == OFS_ADDR_SEL_A) begin
      rdVal = addrSelA_q;
    end else if (regOfs == OFS_ADDR_SEL_B) begin
      rdVal = addrSelB_q;
    end else if (regOfs == OFS_MEM_MAP) begin
      rdVal = memMap_q;
    end else if (regOfs == OFS_CELL_LO) begin
      rdVal = cellVec[7:0];
    end else if (regOfs == OFS_CELL_HI) begin
      rdVal = cellVec[15:8];
    end
  end

  // ==========================================================
  // host read data, control block first, then repeater
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hostRdData_q  <= 8'h00;
      hostRdValid_q <= 1'b0;
    end else begin
      hostRdValid_q <= csiopRd | repRead;
      if (csiopRd) begin
        hostRdData_q <= rdVal;
      end else if (repRead) begin
        hostRdData_q <= pinIn[0];
      end
    end
  end

  assign hostRdData  = hostRdData_q;
  assign hostRdValid = hostRdValid_q;

endmodule // pfm_port_function

// file: pfm_pkg.sv
package pfm_pkg;

  // ==========================================================
  // sizes
  localparam int CELL_COUNT = 16;
  localparam int PORT_COUNT = 4;
  localparam int PORT_BITS  = 8;

  // ==========================================================
  // control register offsets inside the control block
  localparam logic [7:0] OFS_ADDR_SEL_A  = 8'h02;
  localparam logic [7:0] OFS_ADDR_SEL_B  = 8'h03;
  localparam logic [7:0] OFS_IN_BASE     = 8'h10;
  localparam logic [7:0] OFS_OUT_BASE    = 8'h14;
  localparam logic [7:0] OFS_DIR_BASE    = 8'h18;
  localparam logic [7:0] OFS_MEM_MAP     = 8'h1c;
  localparam logic [7:0] OFS_CELL_LO     = 8'h20;
  localparam logic [7:0] OFS_CELL_HI     = 8'h21;

  // ==========================================================
  // field positions, values after reset and the unmapped read value
  localparam int         REPEATER_EN_BIT = 7;
  localparam logic [7:0] RST_PORT_REG    = 8'h00;
  localparam logic [7:0] RST_ADDR_SEL_B  = 8'h00;
  localparam logic [7:0] RD_UNMAPPED     = 8'h00;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    FF_D  = 2'b00,
    FF_T  = 2'b01,
    FF_JK = 2'b10,
    FF_SR = 2'b11
  } pfm_ff_t;

  typedef enum logic [1:0] {
    RT_A    = 2'b00,
    RT_B    = 2'b01,
    RT_C    = 2'b10,
    RT_NONE = 2'b11
  } pfm_route_t;

  typedef struct packed {
    pfm_ff_t    ffType;
    logic       xorInvert;
    logic       useReg;
    logic       sharedClk;
    logic       lendNative;
    logic       borrow;
    pfm_route_t route;
    logic [2:0] routeBit;
  } pfm_cell_cfg_t;

  typedef struct packed {
    logic native;
    logic second;
    logic clkTerm;
    logic presetTerm;
    logic clearTerm;
  } pfm_cell_pt_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wrData;
    logic        rd;
    logic        wr;
    logic        ale;
    logic        csiopSel;
  } pfm_host_t;

  typedef struct packed {
    logic useRep;
    logic repDrive;
    logic repData;
    logic forceIn;
    logic useLogic;
    logic logicData;
    logic useAddr;
    logic addrData;
    logic useCs;
    logic csData;
    logic ioDir;
    logic ioData;
  } pfm_pin_src_t;

endpackage

// file: pfm_output_macrocell.sv
`timescale 1ns/1ps
module pfm_output_macrocell
  import pfm_pkg::*;
(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          srst,
  // configuration and product terms
  input  wire pfm_cell_cfg_t cfg,
  input  wire pfm_cell_pt_t  pt,
  input  wire logic          sharedRise,
  input  wire logic          borrowIn,
  // results
  output logic               spareOut,
  output logic               cellOut
);

  logic sumTerm;
  logic polTerm;
  logic clkPrev_q;
  logic tick;
  logic state_d;
  logic state_q;

  // ==========================================================
  // product term sum and polarity
  assign spareOut = cfg.lendNative & pt.native;
  assign sumTerm  = (pt.native & ~cfg.lendNative)
                  | (cfg.borrow & borrowIn);
  assign polTerm  = sumTerm ^ cfg.xorInvert;

  // ==========================================================
  // clock source: own term edge or shared pin edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clkPrev_q <= 1'b0;
    end else begin
      clkPrev_q <= pt.clkTerm;
    end
  end

  assign tick = cfg.sharedClk ? sharedRise
                              : (pt.clkTerm & ~clkPrev_q);

  // ==========================================================
  // storage element behaviour
  always_comb begin
    case (cfg.ffType)
      FF_D:  state_d = polTerm;
      FF_T:  state_d = state_q ^ polTerm;
      FF_JK: state_d = state_q ? ~pt.second : polTerm;
      default: begin
        if (polTerm) begin
          state_d = 1'b1;
        end else if (pt.second) begin
          state_d = 1'b0;
        end else begin
          state_d = state_q;
        end
      end
    endcase
  end

  // clear beats preset, both levels, clock on rising edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= 1'b0;
    end else if (pt.clearTerm) begin
      state_q <= 1'b0;
    end else if (pt.presetTerm) begin
      state_q <= 1'b1;
    end else if (tick) begin
      state_q <= state_d;
    end
  end

  assign cellOut = cfg.useReg ? state_q : polTerm;

endmodule // pfm_output_macrocell

// file: pfm_pin_cell.sv
`timescale 1ns/1ps
module pfm_pin_cell
  import pfm_pkg::*;
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // candidate sources
  input  wire pfm_pin_src_t src,
  // pin driver
  output logic              pinOut,
  output logic              pinOeN
);

  logic out_q;
  logic oeN_q;

  // ==========================================================
  // function priority per pin
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      out_q <= 1'b0;
      oeN_q <= 1'b1;
    end else if (src.useRep) begin
      out_q <= src.repData;
      oeN_q <= ~src.repDrive;
    end else if (src.forceIn) begin
      out_q <= 1'b0;
      oeN_q <= 1'b1;
    end else if (src.useLogic) begin
      out_q <= src.logicData;
      oeN_q <= 1'b0;
    end else if (src.useAddr) begin
      out_q <= src.addrData;
      oeN_q <= 1'b0;
    end else if (src.useCs) begin
      out_q <= src.csData;
      oeN_q <= 1'b0;
    end else begin
      out_q <= src.ioData;
      oeN_q <= ~src.ioDir;
    end
  end

  assign pinOut = out_q;
  assign pinOeN = oeN_q;

endmodule // pfm_pin_cell

// file: pfm_chk.sv
`timescale 1ns/1ps
module pfm_chk
  import pfm_pkg::*;
#(
  parameter int CELL_N = CELL_COUNT
) (
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            srst,
  // host side
  input wire pfm_host_t       hostBus,
  input wire logic [7:0]      hostRdData,
  input wire logic            hostRdValid,
  // static and array inputs
  input wire logic [2:0][7:0] logicPinMask,
  input wire logic            portARepeater,
  input wire logic [7:0]      chipSelMask,
  input wire logic            sharedClkEn,
  input wire logic [7:0]      chipSelect,
  input wire logic            rangeSelFirst,
  input wire logic            rangeSelSecond,
  // pins
  input wire logic [3:0][7:0] pinIn,
  input wire logic [3:0][7:0] pinOut,
  input wire logic [3:0][7:0] pinOeN
);
  // ==========================================================
  // shadow of the repeater enable bit
  logic repEn_q;
  logic hit;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      repEn_q <= 1'b0;
    end else if (hostBus.csiopSel && hostBus.wr &&
                 hostBus.addr[7:0] == OFS_MEM_MAP) begin
      repEn_q <= hostBus.wrData[REPEATER_EN_BIT];
    end
  end
  assign hit = portARepeater && repEn_q && !hostBus.csiopSel &&
               (rangeSelFirst || rangeSelSecond);

  // ==========================================================
  // assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  rst_state_a: assert property (disable iff (1'b0)
    srst |=> pinOeN == '1 && !hostRdValid) else $error("reset state");
  reg_rd_a: assert property (
    hostBus.csiopSel && hostBus.rd |=> hostRdValid) else $error("no rd");
  rep_drive_a: assert property (
    hit && hostBus.wr |=> pinOeN[0] == 8'h00 &&
    pinOut[0] == $past(hostBus.wrData)) else $error("repeater write");
  rep_read_a: assert property (
    hit && hostBus.rd && !hostBus.wr |=> hostRdValid && pinOeN[0] == 8'hff
    && hostRdData == $past(pinIn[0])) else $error("repeater read");
  rep_idle_a: assert property (
    portARepeater && !(hit && hostBus.wr) |=> pinOeN[0] == 8'hff)
    else $error("repeater idle drive");
  cs_out_a: assert property (
    !$past(srst) && chipSelMask == 8'hff && !sharedClkEn |=>
    pinOeN[3] == 8'h00 && pinOut[3] == $past(chipSelect))
    else $error("chip select");
  clk_pin_a: assert property (
    sharedClkEn |=> pinOeN[3][1]) else $error("clock pin driven");
  logic_pin_a: assert property (
    logicPinMask[2][0] |=> !pinOeN[2][0]) else $error("logic pin off");

  cover property (hit && hostBus.wr);
  cover property (hit && hostBus.rd);
  cover property (hostBus.csiopSel && hostBus.rd);
endmodule // pfm_chk

bind pfm_port_function pfm_chk #(.CELL_N(CELL_N)) u_chk (
  .sys_clk(sys_clk), .srst(srst), .hostBus(hostBus),
  .hostRdData(hostRdData), .hostRdValid(hostRdValid),
  .logicPinMask(logicPinMask), .portARepeater(portARepeater),
  .chipSelMask(chipSelMask), .sharedClkEn(sharedClkEn),
  .chipSelect(chipSelect), .rangeSelFirst(rangeSelFirst),
  .rangeSelSecond(rangeSelSecond), .pinIn(pinIn), .pinOut(pinOut),
  .pinOeN(pinOeN)
);

// file: pfm_far_model.sv
`timescale 1ns/1ps
module pfm_far_model (
  // bench stimulus
  input  wire logic [7:0]      periphByte,
  input  wire logic            clkPin,
  // block pins
  input  wire logic [3:0][7:0] pinOut,
  input  wire logic [3:0][7:0] pinOeN,
  output logic [3:0][7:0]      pinIn
);
  // ==========================================================
  // wire level per pin; released A pins show periphByte, D1 clkPin, others the inverse
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (!pinOeN[p][b]) begin
          pinIn[p][b] = pinOut[p][b];
        end else if (p == 0) begin
          pinIn[p][b] = periphByte[b];
        end else if (p == 3 && b == 1) begin
          pinIn[p][b] = clkPin;
        end else begin
          pinIn[p][b] = ~pinOut[p][b];
        end
      end
    end
  end
endmodule // pfm_far_model

// file: tb.sv
`timescale 1ns/1ps
module tb;
  import pfm_pkg::*;
  logic                             sys_clk;
  logic                             srst;
  pfm_host_t                        hostBus;
  logic [7:0]                       hostRdData;
  logic                             hostRdValid;
  logic [2:0][7:0]                  logicPinMask;
  logic                             portBHighAddr;
  logic                             portARepeater;
  logic [7:0]                       chipSelMask;
  logic                             sharedClkEn;
  pfm_cell_cfg_t [CELL_COUNT-1:0]   cellCfg;
  pfm_cell_pt_t [CELL_COUNT-1:0]    cellPt;
  logic [7:0]                       chipSelect;
  logic                             rangeSelFirst;
  logic                             rangeSelSecond;
  logic [CELL_COUNT-1:0]            cellFeedback;
  logic [3:0][7:0]                  pinIn;
  logic [3:0][7:0]                  pinOut;
  logic [3:0][7:0]                  pinOeN;
  logic [7:0]                       periphByte;
  logic                             clkPin;
  logic [7:0]                       seenOut;
  logic [7:0]                       seenOeN;
  logic                             seenValid;
  int                               err_total;
  int                               checked;

  pfm_port_function #(.CELL_N(CELL_COUNT)) u_dut (
    .sys_clk(sys_clk), .srst(srst), .hostBus(hostBus),
    .hostRdData(hostRdData), .hostRdValid(hostRdValid),
    .logicPinMask(logicPinMask), .portBHighAddr(portBHighAddr),
    .portARepeater(portARepeater), .chipSelMask(chipSelMask),
    .sharedClkEn(sharedClkEn), .cellCfg(cellCfg), .cellPt(cellPt),
    .chipSelect(chipSelect), .rangeSelFirst(rangeSelFirst),
    .rangeSelSecond(rangeSelSecond), .cellFeedback(cellFeedback),
    .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN)
  );
  pfm_far_model u_far (
    .periphByte(periphByte), .clkPin(clkPin), .pinOut(pinOut),
    .pinOeN(pinOeN), .pinIn(pinIn)
  );

  // ==========================================================
  // tasks
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ctl is rd, wr, ale, csiopSel; range only on data cycles
  task automatic bus(logic [15:0] a, logic [7:0] d, logic [3:0] ctl,
                     logic [1:0] rs);
    @(posedge sys_clk);
    hostBus <= {a, d, ctl};
    {rangeSelFirst, rangeSelSecond} <= rs;
    @(posedge sys_clk);
    hostBus <= '0;
    {rangeSelFirst, rangeSelSecond} <= 2'b00;
    #1;
    seenOut   = pinOut[0];
    seenOeN   = pinOeN[0];
    seenValid = hostRdValid;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    bus({8'h00, a}, d, 4'b0101, 2'b00);
  endtask
  task automatic reg_rd(logic [7:0] a);
    bus({8'h00, a}, 8'h00, 4'b1001, 2'b00);
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse(logic shared);
    @(posedge sys_clk);
    if (shared) clkPin <= 1'b1;
    else cellPt[0].clkTerm <= 1'b1;
    @(posedge sys_clk);
    clkPin <= 1'b0;
    cellPt[0].clkTerm <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // ==========================================================
  // clock, watchdog, tests
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end
  initial begin
    {hostBus, logicPinMask, portBHighAddr, portARepeater} = '0;
    {sharedClkEn, cellCfg, cellPt, rangeSelFirst, rangeSelSecond} = '0;
    {err_total, checked, clkPin} = '0;
    {chipSelMask, chipSelect, periphByte, srst} = {24'hff3cc3, 1'b1};
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    reg_rd(OFS_ADDR_SEL_B);
    check("addr select B", hostRdData, RST_ADDR_SEL_B);
    check("port B oe", pinOeN[1], 8'hff);
    reg_wr(OFS_DIR_BASE + 8'h01, 8'h0f);
    reg_wr(OFS_OUT_BASE + 8'h01, 8'h5a);
    check("port B oe", pinOeN[1], 8'hf0);
    check("port B out", pinOut[1] & 8'h0f, 8'h0a);
    reg_rd(OFS_IN_BASE + 8'h01);
    check("port B in", hostRdData & 8'h0f, 8'h0a);
    reg_wr(OFS_ADDR_SEL_B, 8'h0c);
    bus(16'h1234, 8'h00, 4'b0010, 2'b00);
    check("low address", pinOut[1] & 8'h0f, 8'h06);
    @(posedge sys_clk);
    portBHighAddr <= 1'b1;
    settle();
    check("high address", pinOut[1] & 8'h0f, 8'h02);
    check("port D select", pinOut[3], 8'h3c);
    @(posedge sys_clk);
    logicPinMask[2] <= 8'h01;
    cellCfg[0] <= {FF_D, 5'b10000, RT_C, 3'd0};
    cellPt[0].native <= 1'b1;
    reg_wr(OFS_DIR_BASE + 8'h02, 8'hff);
    reg_wr(OFS_OUT_BASE + 8'h02, 8'hff);
    check("cell pin", pinOut[2] & 8'h01, 8'h00);
    check("feedback", {7'h00, cellFeedback[0]}, 8'h00);
    reg_rd(OFS_CELL_LO);
    check("cell read", hostRdData & 8'h01, 8'h00);
    @(posedge sys_clk);
    cellCfg[0] <= {FF_D, 5'b00001, RT_C, 3'd0};
    cellCfg[1].lendNative <= 1'b1;
    cellPt[0].native <= 1'b0;
    cellPt[1].native <= 1'b1;
    settle();
    check("borrow", pinOut[2] & 8'h01, 8'h01);
    for (int t = 0; t < 4; t++) begin
      @(posedge sys_clk);
      cellCfg[0] <= {pfm_ff_t'(t), 5'b01000, RT_C, 3'd0};
      cellPt[0] <= 5'b10001;
      settle();
      check("cleared", {7'h00, cellFeedback[0]}, 8'h00);
      cellPt[0].clearTerm <= 1'b0;
      pulse(1'b0);
      check("first clock", {7'h00, cellFeedback[0]}, 8'h01);
      cellPt[0].second <= 1'b1;
      pulse(1'b0);
      check("second clock", {7'h00, cellFeedback[0]},
            {7'h00, t == 0 || t == 3});
    end
    cellPt[0] <= 5'b10010;
    settle();
    check("preset", {7'h00, cellFeedback[0]}, 8'h01);
    cellPt[0] <= 5'b10001;
    cellCfg[0].sharedClk <= 1'b1;
    sharedClkEn <= 1'b1;
    settle();
    cellPt[0].clearTerm <= 1'b0;
    pulse(1'b1);
    check("shared clock", {7'h00, cellFeedback[0]}, 8'h01);
    @(posedge sys_clk);
    portARepeater <= 1'b1;
    reg_wr(OFS_DIR_BASE, 8'hff);
    reg_wr(OFS_OUT_BASE, 8'hff);
    check("port A taken", pinOeN[0], 8'hff);
    bus(16'h8000, 8'ha5, 4'b0100, 2'b10);
    check("not enabled", seenOeN, 8'hff);
    reg_wr(OFS_MEM_MAP, 8'h80);
    bus(16'h8000, 8'ha5, 4'b0100, 2'b01);
    check("repeat out", seenOut, 8'ha5);
    check("repeat oe", seenOeN, 8'h00);
    bus(16'h8000, 8'h5a, 4'b0100, 2'b00);
    check("out of range", seenOeN, 8'hff);
    bus(16'h8000, 8'h00, 4'b1000, 2'b10);
    check("repeat in", hostRdData, 8'hc3);
    check("repeat valid", {7'h00, seenValid}, 8'h01);
    reg_rd(8'h40);
    check("unmapped", hostRdData, RD_UNMAPPED);
    print_verdict();
  end
endmodule // tb
